// ===== core/neg_pkg.sv
package neg_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_LOC_LO    = 8'h04;
	localparam logic [7:0] ADDR_LOC_HI    = 8'h08;
	localparam logic [7:0] ADDR_PART_LO   = 8'h0C;
	localparam logic [7:0] ADDR_PART_HI   = 8'h10;
	localparam logic [7:0] ADDR_STATUS    = 8'h14;

	// Control register fields
	localparam int CTRL_ENABLE    = 0;
	localparam int CTRL_BYPASS    = 1;
	localparam int CTRL_LOC_NP    = 2;
	localparam int CTRL_CONFIRM   = 3;
	localparam int CTRL_SEED_LOAD = 4;
	localparam int CTRL_LANE_LSB  = 8;
	localparam int CTRL_SEED_LSB  = 16;
	localparam logic [31:0] CTRL_RESET = 32'h00000F00;

	// Status register fields
	localparam int STAT_PAGE_AVAIL = 0;
	localparam int STAT_PARTNER_NP = 1;
	localparam int STAT_TX_VALID   = 2;
	localparam int STAT_STATE_LSB  = 4;
	localparam int STAT_NONCE_LSB  = 8;

	// Next-page codeword bit positions
	localparam int BIT_NP     = 15;
	localparam int BIT_ACK    = 14;
	localparam int BIT_MP     = 13;
	localparam int BIT_TOGGLE = 12;
	localparam int BIT_ACK2   = 11;

	// Null message page code in bits 10:0
	localparam logic [10:0] NULL_MESSAGE = 11'h001;

	// Nonce generator taps, x8+x6+x5+x4+1 in Galois form
	localparam logic [7:0] NONCE_TAPS    = 8'hB8;
	localparam logic [7:0] NONCE_NONZERO = 8'h01;

	// Training frame length in clock cycles
	localparam int FRAME_CYCLES = 64;
	localparam int LANES        = 4;

	// Negotiation sequencer states
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_BYPASS = 2'b01,
		ST_PAGES  = 2'b10,
		ST_TRAIN  = 2'b11
	} neg_state_t;

endpackage

// ===== core/frame_pulse.sv
`timescale 1ns/1ps

module frame_pulse #(
	parameter int FRAME_LEN = 64
) (
	input  wire logic core_clk,
	input  wire logic rst_sync_n,
	input  wire logic run,
	output logic      start
);

	localparam int CW = $clog2(FRAME_LEN);

	logic [CW-1:0] count_q;   // Position inside the current frame

	// Frame position; restarts from zero whenever the lane is stopped
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count_q <= '0;
		end else if (!run || count_q == CW'(FRAME_LEN - 1)) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	// Registered one-cycle strobe, in the cycle after the frame position is zero
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			start <= 1'b0;
		end else begin
			start <= run && count_q == '0;
		end
	end

endmodule

// ===== core/negotiation_ctrl.sv
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps

module negotiation_ctrl #(
	parameter int FRAME_LEN = neg_pkg::FRAME_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [47:0] partner_page_in,
	input  wire logic        partner_page_strobe,
	output logic [47:0]      tx_page_word,
	output logic             tx_page_valid,
	output logic [47:0]      partner_next_page_word,
	output logic [3:0]       training_frame_start,
	output logic             pcs_direct_connect,
	output logic             negotiation_active
);

	// Reset release synchroniser; the clock is assumed free running
	logic rst_meta_q;
	logic rst_sync_n;

	// Bus data-phase capture
	logic       wr_pend_q;    // Write data phase in progress
	logic       rd_pend_q;    // Read data phase, first (wait) cycle
	logic [7:0] addr_q;       // Word-aligned byte offset captured at the address phase

	// Software registers
	logic [31:0] ctrl_q;         // Enable, bypass, flag, lane mask, seed
	logic [47:0] local_word_q;   // Host-supplied next-page word
	logic        confirm_q;      // One-cycle read-confirm strobe from software
	logic        seed_load_q;    // One-cycle seed load strobe

	// Partner link capture
	logic        strobe_meta_q;
	logic        strobe_sync_q;
	logic        strobe_last_q;
	logic        page_avail_q;    // Unread partner page waiting for the host
	logic        partner_more_q;  // Partner announced further pages

	// Sequencer and transmit side
	neg_pkg::neg_state_t state_q;
	logic        toggle_q;        // Toggle bit for the next page fetched
	logic [7:0]  nonce_q;         // Nonce polynomial generator state

	logic        addr_phase;
	logic        wr_en;
	logic        new_page;
	logic        enable;
	logic        bypass;
	logic        loc_flag;
	logic [47:0] next_tx;
	logic [31:0] rd_mux;

	assign enable   = ctrl_q[neg_pkg::CTRL_ENABLE];
	assign bypass   = ctrl_q[neg_pkg::CTRL_BYPASS];
	assign loc_flag = ctrl_q[neg_pkg::CTRL_LOC_NP];

	// Async assert, synchronous release of the negotiation reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Only NONSEQ/SEQ transfers while the bus is ready start a data phase
	assign addr_phase = hsel && hready && htrans[1];

	// Capture the address phase; reads get one wait cycle for a fresh read
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			rd_pend_q <= addr_phase && !hwrite;
			if (addr_phase) begin
				addr_q <= {haddr[7:2], 2'b00};
			end
		end
	end

	// Wait state only in the first read data cycle; never an error
	assign hreadyout = !rd_pend_q;
	assign hresp     = 1'b0;
	assign wr_en     = wr_pend_q;

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (addr_q)
			neg_pkg::ADDR_CTRL:    rd_mux = ctrl_q;
			neg_pkg::ADDR_LOC_LO:  rd_mux = local_word_q[31:0];
			neg_pkg::ADDR_LOC_HI:  rd_mux = {16'h0000, local_word_q[47:32]};
			neg_pkg::ADDR_PART_LO: rd_mux = partner_next_page_word[31:0];
			neg_pkg::ADDR_PART_HI: rd_mux = {16'h0000, partner_next_page_word[47:32]};
			neg_pkg::ADDR_STATUS: begin
				rd_mux[neg_pkg::STAT_PAGE_AVAIL]                   = page_avail_q;
				rd_mux[neg_pkg::STAT_PARTNER_NP]                   = partner_more_q;
				rd_mux[neg_pkg::STAT_TX_VALID]                     = tx_page_valid;
				rd_mux[neg_pkg::STAT_STATE_LSB +: 2]               = state_q;
				rd_mux[neg_pkg::STAT_NONCE_LSB +: 8]               = nonce_q;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Read data is registered in the wait cycle and held afterwards
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend_q) begin
			hrdata <= rd_mux;
		end
	end

	// Control register; confirm and seed-load bits are strobes, never stored
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_q      <= neg_pkg::CTRL_RESET;
			confirm_q   <= 1'b0;
			seed_load_q <= 1'b0;
		end else begin
			confirm_q   <= 1'b0;
			seed_load_q <= 1'b0;
			if (wr_en && addr_q == neg_pkg::ADDR_CTRL) begin
				ctrl_q <= hwdata & ~((32'h1 << neg_pkg::CTRL_CONFIRM)
					| (32'h1 << neg_pkg::CTRL_SEED_LOAD));
				confirm_q   <= hwdata[neg_pkg::CTRL_CONFIRM];
				seed_load_q <= hwdata[neg_pkg::CTRL_SEED_LOAD];
			end
		end
	end

	// Host next-page word, written in two halves
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			local_word_q <= 48'h000000000000;
		end else if (wr_en && addr_q == neg_pkg::ADDR_LOC_LO) begin
			local_word_q[31:0] <= hwdata;
		end else if (wr_en && addr_q == neg_pkg::ADDR_LOC_HI) begin
			local_word_q[47:32] <= hwdata[15:0];
		end
	end

	// Partner strobe crosses in from the link; edge taken after two flops
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			strobe_meta_q <= 1'b0;
			strobe_sync_q <= 1'b0;
			strobe_last_q <= 1'b0;
		end else begin
			strobe_meta_q <= partner_page_strobe;
			strobe_sync_q <= strobe_meta_q;
			strobe_last_q <= strobe_sync_q;
		end
	end

	// Partner holds its word steady while the strobe is high
	assign new_page = strobe_sync_q && !strobe_last_q && state_q == neg_pkg::ST_PAGES;

	// Latest partner page and its flags; a new page wins over the confirm
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			partner_next_page_word <= 48'h000000000000;
			partner_more_q         <= 1'b0;
			page_avail_q           <= 1'b0;
		end else if (new_page) begin
			partner_next_page_word <= partner_page_in;
			partner_more_q         <= partner_page_in[neg_pkg::BIT_NP];
			page_avail_q           <= 1'b1;
		end else if (confirm_q) begin
			page_avail_q <= 1'b0;
		end
	end

	// Next outgoing page: host word with generated control bits, or a null
	always_comb begin
		next_tx = 48'h000000000000;
		if (loc_flag) begin
			next_tx = local_word_q;
			next_tx[neg_pkg::BIT_MP] = local_word_q[neg_pkg::BIT_MP];
		end else begin
			next_tx[10:0] = neg_pkg::NULL_MESSAGE;
			next_tx[neg_pkg::BIT_MP] = 1'b1;
		end
		next_tx[neg_pkg::BIT_NP]     = loc_flag;
		// The page fetched by a host confirm carries the acknowledge itself
		next_tx[neg_pkg::BIT_ACK]    = confirm_q;
		next_tx[neg_pkg::BIT_TOGGLE] = toggle_q;
		next_tx[neg_pkg::BIT_ACK2]   = 1'b0;
	end

	// Negotiation sequencer
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q <= neg_pkg::ST_OFF;
		end else if (bypass) begin
			state_q <= neg_pkg::ST_BYPASS;
		end else if (!enable) begin
			state_q <= neg_pkg::ST_OFF;
		end else begin
			unique case (state_q)
				neg_pkg::ST_OFF, neg_pkg::ST_BYPASS: begin
					// Without a local page the sequencer goes straight to training
					state_q <= loc_flag ? neg_pkg::ST_PAGES : neg_pkg::ST_TRAIN;
				end
				neg_pkg::ST_PAGES: begin
					if (confirm_q && !loc_flag && !partner_more_q && !new_page) begin
						state_q <= neg_pkg::ST_TRAIN;
					end
				end
				neg_pkg::ST_TRAIN: begin
					// A later partner page is taken up with null pages
					if (strobe_sync_q && !strobe_last_q) begin
						state_q <= neg_pkg::ST_PAGES;
					end
				end
			endcase
		end
	end

	// Transmit page: fetched on entry and on every host confirm
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tx_page_word  <= 48'h000000000000;
			tx_page_valid <= 1'b0;
			toggle_q      <= 1'b0;
		end else if (state_q != neg_pkg::ST_PAGES || bypass || !enable) begin
			// Drops with the state change, so no page outlives bypass or disable
			tx_page_valid <= 1'b0;
			toggle_q      <= 1'b0;
		end else if (!tx_page_valid || confirm_q) begin
			tx_page_word  <= next_tx;
			tx_page_valid <= 1'b1;
			toggle_q      <= !toggle_q;
		end
	end

	// Nonce generator: seeded by software, steps while negotiating
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			nonce_q <= neg_pkg::NONCE_NONZERO;
		end else if (seed_load_q) begin
			// An all-zero seed would lock the generator
			nonce_q <= (ctrl_q[neg_pkg::CTRL_SEED_LSB +: 8] == 8'h00)
				? neg_pkg::NONCE_NONZERO : ctrl_q[neg_pkg::CTRL_SEED_LSB +: 8];
		end else if (negotiation_active) begin
			nonce_q <= nonce_q[0] ? ((nonce_q >> 1) ^ neg_pkg::NONCE_TAPS) : (nonce_q >> 1);
		end
	end

	assign negotiation_active = state_q == neg_pkg::ST_PAGES || state_q == neg_pkg::ST_TRAIN;
	assign pcs_direct_connect = state_q == neg_pkg::ST_BYPASS;

	// One frame timer per lane; bit index is the lane number
	for (genvar lane = 0; lane < neg_pkg::LANES; lane++) begin : g_lane
		frame_pulse #(
			.FRAME_LEN (FRAME_LEN)
		) u_frame (
			.core_clk   (core_clk),
			.rst_sync_n (rst_sync_n),
			.run        (state_q == neg_pkg::ST_TRAIN && ctrl_q[neg_pkg::CTRL_LANE_LSB + lane]),
			.start      (training_frame_start[lane])
		);
	end

endmodule

// ===== tb/negotiation_ctrl_sva.sv
`timescale 1ns/1ps
// Watches bus answers, page words and frame pulses at the top ports
module negotiation_ctrl_sva (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        partner_page_strobe,
	input wire logic [47:0] tx_page_word,
	input wire logic        tx_page_valid,
	input wire logic [47:0] partner_next_page_word,
	input wire logic [3:0]  training_frame_start,
	input wire logic        pcs_direct_connect,
	input wire logic        negotiation_active
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Request accepted at this edge
	wire bus_take = hsel && hready && htrans[1];
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not OKAY");
	a_read_wait: assert property (bus_take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait cycle wrong");
	a_write_nowait: assert property (bus_take && hwrite |=> hreadyout)
		else $error("write inserted a wait");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	a_frame_single: assert property (training_frame_start != 4'h0 |=> training_frame_start == 4'h0)
		else $error("frame start wider than one cycle");
	a_frame_active: assert property (training_frame_start != 4'h0 |-> negotiation_active || $past(negotiation_active))
		else $error("frame start while negotiation off");
	a_bypass_quiet: assert property (pcs_direct_connect |-> !negotiation_active && !tx_page_valid)
		else $error("negotiation runs in bypass");
	a_valid_active: assert property (tx_page_valid |-> negotiation_active)
		else $error("page sent while inactive");
	a_gen_bit: assert property (tx_page_valid |-> !tx_page_word[11])
		else $error("generated bit 11 not clear");
	a_null_page: assert property (tx_page_valid && !tx_page_word[15] |-> tx_page_word[13] && tx_page_word[10:0] == 11'h001)
		else $error("null message page malformed");
	a_page_capture: assert property ($changed(partner_next_page_word) |-> $past(partner_page_strobe))
		else $error("partner word changed without strobe");
endmodule
bind negotiation_ctrl negotiation_ctrl_sva chk (.core_clk, .rst_n, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hrdata, .hresp, .partner_page_strobe, .tx_page_word, .tx_page_valid,
	.partner_next_page_word, .training_frame_start, .pcs_direct_connect, .negotiation_active);

// ===== tb/partner_model.sv
`timescale 1ns/1ps
// Remote partner: hands over one page word qualified by a strobe level
module partner_model (
	input wire logic        core_clk,
	output logic [47:0]     partner_page_in,
	output logic            partner_page_strobe,
	input wire logic [47:0] tx_page_word,
	input wire logic        tx_page_valid
);
	// Idle data is never a stale copy of a real page
	initial begin
		partner_page_in = 48'hFFFFFFFFFFFF;
		partner_page_strobe = 1'b0;
	end
	// Gap sets prompt or slow answers; data outlives the capture by a margin
	task automatic send(input logic [47:0] w, input int gap);
		repeat (gap) @(posedge core_clk);
		partner_page_in <= w;
		partner_page_strobe <= 1'b1;
		repeat (5) @(posedge core_clk);
		partner_page_strobe <= 1'b0;
		repeat (3) @(posedge core_clk);
		partner_page_in <= ~w;
	endtask
endmodule

// ===== tb/tb_negotiation_ctrl.sv
`timescale 1ns/1ps
// Register-level bench: bus tasks, partner pages, output checks
module tb_negotiation_ctrl;
	localparam int FL = 8; // Short frame keeps the run brief
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, tx_page_valid, partner_page_strobe;
	logic        pcs_direct_connect, negotiation_active, rdy_s;
	logic [31:0] hrdata, rd, rd_s;
	logic [47:0] partner_page_in, tx_page_word, partner_next_page_word;
	logic [3:0]  training_frame_start;
	logic [7:0]  seeds [2] = '{8'h5A, 8'h00};
	int          n_errors = 0;
	int          n_compared = 0;
	int          cnt [4];
	always #10 core_clk = ~core_clk;
	// Bus state as it stands just ahead of each rising edge
	always @(negedge core_clk) begin
		rdy_s = hreadyout;
		rd_s = hrdata;
	end
	negotiation_ctrl #(.FRAME_LEN(FL)) uut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .partner_page_in,
		.partner_page_strobe, .tx_page_word, .tx_page_valid, .partner_next_page_word,
		.training_frame_start, .pcs_direct_connect, .negotiation_active);
	partner_model pm (.core_clk, .partner_page_in, .partner_page_strobe, .tx_page_word,
		.tx_page_valid);
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One single AHB transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk); // Requests always start just after a rising edge
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (rdy_s !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (rdy_s !== 1'b1);
		rd = rd_s;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(what, {16'h0, rd & m}, {16'h0, exp});
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd_chk("ctrl", 8'h00, 32'hFFFFFFFF, 32'h00000F00);
		rd_chk("status", 8'h14, 32'hFFFFFFFF, 32'h00000100);
		xfer(1'b1, 8'h14, 32'hFFFFFFFF);
		rd_chk("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0);
		rd_chk("status_ro", 8'h14, 32'hFFFFFFFF, 32'h00000100);
		// Zero seed must not lock the generator
		foreach (seeds[i]) begin
			xfer(1'b1, 8'h00, {8'h0, seeds[i], 16'h0F10});
			rd_chk("nonce", 8'h14, 32'hFF00, {16'h0, seeds[i] == 8'h0 ? 8'h01 : seeds[i], 8'h0});
		end
		$display("test reset and seed done");
		xfer(1'b1, 8'h00, 32'h00000F03);
		wait_n(2);
		check("bypass", {46'h0, pcs_direct_connect, negotiation_active}, 48'h2);
		// No next pages: straight to training, lanes 0 and 2 only
		xfer(1'b1, 8'h00, 32'h00000501);
		cnt = '{0, 0, 0, 0};
		repeat (30) begin
			@(negedge core_clk);
			for (int l = 0; l < 4; l++)
				cnt[l] += training_frame_start[l];
		end
		foreach (cnt[l]) check("frames", 48'(cnt[l]), l % 2 == 0 ? 48'(30 / FL + 1) : 48'h0);
		rd_chk("train", 8'h14, 32'h30, 32'h30);
		xfer(1'b1, 8'h00, 32'h00000F00);
		wait_n(2);
		check("off", {47'h0, negotiation_active}, 48'h0);
		$display("test modes done");
		xfer(1'b1, 8'h04, 32'hA5A55A5A);
		xfer(1'b1, 8'h08, 32'h0000C3C3);
		xfer(1'b1, 8'h00, 32'h00000F05);
		wait_n(3);
		check("tx_first", tx_page_word, 48'hC3C3A5A5825A);
		check("tx_valid", {47'h0, tx_page_valid}, 48'h1);
		pm.send(48'h000012348001, 2);
		wait_n(2);
		check("partner", partner_next_page_word, 48'h000012348001);
		rd_chk("part_lo", 8'h0C, 32'hFFFFFFFF, 32'h12348001);
		rd_chk("avail", 8'h14, 32'h37, 32'h27);
		// Confirm fetches a page carrying the message bit
		xfer(1'b1, 8'h04, 32'h00002000);
		xfer(1'b1, 8'h00, 32'h00000F0D);
		wait_n(3);
		check("tx_next", tx_page_word, 48'hC3C30000F000);
		rd_chk("avail_clr", 8'h14, 32'h1, 32'h0);
		$display("test pages done");
		// Flag low while the partner still has pages: null pages
		xfer(1'b1, 8'h00, 32'h00000F09);
		wait_n(3);
		check("null", tx_page_word & 48'hA7FF, 48'h2001);
		pm.send(48'h000000000001, 9);
		xfer(1'b1, 8'h00, 32'h00000F09);
		wait_n(3);
		rd_chk("to_train", 8'h14, 32'h37, 32'h30);
		// A partner page during training pulls the sequencer back to pages
		pm.send(48'h000000000001, 2);
		rd_chk("re_pages", 8'h14, 32'h34, 32'h24);
		$display("test null pages done");
		print_verdict();
	end
endmodule
